// ==== hw/sps_pkg.sv ====
/*
 * Shared constants and types for the sector protection and page decode
 * block: control block offsets, field positions, decode terms and timing.
 * Assumes a single 125 MHz clock domain and one processor data port.
 */
// Notes on behaviour
// R1 - Each sector keeps its own protection bit
// R2 - Only programmer port changes protection bits
// R3 - Writes or erases to protected sectors dropped
// R4 - Verify on protected sector returns stored data
// R5 - Main status: bit i is sector i
// R6 - Secondary status: bits 3-0 sectors, bit 7 lock
// R7 - Lock refuses programmer access to contents
// R8 - Only whole-device erase clears the lock
// R9 - Processor flash reads continue while locked
// R10 - Reset command returns flash to read array
// R11 - Processor issues reset after status or error
// R12 - Reset ignored during program or bulk erase
// R13 - Reset aborts a running sector erase
// R14 - Page register read/write at offset E0h
// R15 - Page register clears on reset
// R16 - Page bits feed decode and general logic
// R17 - Turbo off: standby after 70 ns stable
// R18 - Five bits gate control signals off logic
// R19 - Eight main, four secondary selects, three terms
// R20 - One select for 256-byte control block
// R21 - Decode produces the JTAG port select
// R22 - Three external selects, one term each
package sps_pkg;
   // Widths and counts
   localparam int ADDR_W  = 16;
   localparam int PAGE_W  = 8;
   localparam int DEC_W   = ADDR_W + PAGE_W;
   localparam int N_MAIN  = 8;
   localparam int N_BOOT  = 4;
   localparam int N_SECT  = N_MAIN + N_BOOT;
   localparam int N_ECS   = 3;
   localparam int N_CNTL  = 5;
   localparam int N_PT    = 3;
   // Control block register offsets
   localparam logic [7:0] OFF_PAGE      = 8'hE0;
   localparam logic [7:0] OFF_MAIN_PROT = 8'hC0;
   localparam logic [7:0] OFF_SEC_PROT  = 8'hC2;
   localparam logic [7:0] OFF_PMODE0    = 8'hB0;
   localparam logic [7:0] OFF_PMODE2    = 8'hB4;
   // Field positions and reset values
   localparam int TURBO_BIT  = 3;
   localparam int LOCK_BIT   = 7;
   localparam logic [7:0] PAGE_RST   = 8'h00;
   localparam logic [7:0] PMODE0_RST = 8'h00;
   localparam logic [7:0] PMODE2_RST = 8'h00;
   localparam logic [7:0] REG_NONE   = 8'h00;
   localparam logic [N_MAIN-1:0] MAIN_PROT_RST = 8'h00;
   localparam logic [N_BOOT-1:0] BOOT_PROT_RST = 4'h0;
   // Flash commands and programmer selects
   localparam logic [7:0] CMD_RESET = 8'hF0;
   localparam logic [3:0] SEL_LOCK  = 4'hF;
   // Decode terms over {page, address}
   localparam logic [DEC_W-1:0] MAIN_MASK = 24'h078000;
   localparam logic [DEC_W-1:0] MAIN_VAL  = 24'h008000;
   localparam logic [DEC_W-1:0] MAIN_STEP = 24'h010000;
   localparam logic [DEC_W-1:0] BOOT_MASK = 24'h00F000;
   localparam logic [DEC_W-1:0] BOOT_VAL  = 24'h004000;
   localparam logic [DEC_W-1:0] BOOT_STEP = 24'h001000;
   localparam logic [DEC_W-1:0] BLK_MASK  = 24'h00FF00;
   localparam logic [DEC_W-1:0] CTRL_VAL  = 24'h003000;
   localparam logic [DEC_W-1:0] JTAG_VAL  = 24'h003100;
   localparam logic [DEC_W-1:0] ECS_VAL   = 24'h002000;
   localparam logic [DEC_W-1:0] ECS_STEP  = 24'h000100;
   localparam logic [DEC_W-1:0] TERM_NONE = 24'h000000;
   // Timing
   localparam int CLK_NS        = 8;
   localparam int CLK_MHZ       = 125;
   localparam int STANDBY_NS    = 70;
   localparam int STANDBY_CYC   = (STANDBY_NS + CLK_NS - 1) / CLK_NS;
   localparam int RESET_US      = 3000;
   localparam int RESET_CYC     = RESET_US * CLK_MHZ;
   // Flash operations and array activity
   typedef enum logic [1:0] {
      OP_PROGRAM = 2'h0, OP_SECTOR_ERASE = 2'h1,
      OP_BULK_ERASE = 2'h2, OP_VERIFY = 2'h3
   } sps_op_e;
   typedef enum logic [1:0] {
      FL_IDLE = 2'h0, FL_PROGRAM = 2'h1, FL_BULK = 2'h2, FL_SECTOR = 2'h3
   } sps_flash_e;
   // Sector 0-7 main, 8-11 secondary
   typedef struct packed {
      sps_op_e    op;
      logic [3:0] sector;
   } sps_flash_req_s;
   // Programmer port command
   typedef struct packed {
      logic       wr;
      logic [3:0] sel;
      logic       val;
      logic       chip_erase;
   } sps_prog_cmd_s;
endpackage

// ==== hw/sps_protect_decode.sv ====
/*
 * Sector protection, content lock, flash reset command, page register,
 * power mode control and the address decode selects.
 * Assumes processor pins are asynchronous and pass the synchroniser;
 * programmer commands and flash requests come from logic on sys_clk.
 */
`timescale 1ns/10ps
module sps_protect_decode #(
   parameter int RESET_CYC = sps_pkg::RESET_CYC
) (
   // Clock and reset
   input  wire logic                          sys_clk,
   input  wire logic                          rst_b,
   // Processor port pins
   input  wire logic [sps_pkg::ADDR_W-1:0]    addr_pin,
   input  wire logic [7:0]                    data_in_pin,
   input  wire logic [sps_pkg::N_CNTL-1:0]    cntl_pin,
   output logic      [7:0]                    data_out,
   output logic                               data_oe,
   // Programmer port
   input  wire sps_pkg::sps_prog_cmd_s        prog_cmd,
   output logic                               prog_access_ok,
   // Flash array side
   input  wire logic                          flash_req_valid,
   input  wire sps_pkg::sps_flash_req_s       flash_req,
   input  wire sps_pkg::sps_flash_e           flash_state,
   output logic                               array_req_valid,
   output sps_pkg::sps_flash_req_s            array_req,
   output logic                               req_discarded,
   output logic                               flash_sm_reset,
   output logic                               reset_busy,
   // Decode selects
   output logic      [sps_pkg::N_MAIN-1:0]    main_sector_selects,
   output logic      [sps_pkg::N_BOOT-1:0]    boot_sector_selects,
   output logic                               ctrl_block_sel,
   output logic                               jtag_sel,
   output logic      [sps_pkg::N_ECS-1:0]     external_selects,
   // General logic side
   output logic      [sps_pkg::PAGE_W-1:0]    page_outputs,
   output logic      [sps_pkg::N_CNTL-1:0]    cntl_to_logic,
   output logic                               pld_standby
);
   localparam int SW = sps_pkg::ADDR_W + 8 + sps_pkg::N_CNTL;
   localparam int DW = sps_pkg::DEC_W;
   localparam int CW = $clog2(RESET_CYC + 1);
   localparam logic [CW-1:0] RESET_LAST = CW'(RESET_CYC - 1);
   localparam logic [3:0] STBY_LAST = 4'(sps_pkg::STANDBY_CYC);

   typedef enum logic [1:0] {RC_IDLE = 2'b01, RC_BUSY = 2'b10} sps_rc_e;

   logic [SW-1:0]                  sync_bus;
   logic [sps_pkg::ADDR_W-1:0]     addr_s;
   logic [7:0]                     data_s;
   logic [sps_pkg::N_CNTL-1:0]     cntl_s;
   logic                           wr_prev;
   logic                           wr_end;
   logic                           rd_act;
   logic [7:0]                     pmode0;
   logic [7:0]                     pmode2;
   logic [sps_pkg::N_MAIN-1:0]     main_prot;
   logic [sps_pkg::N_BOOT-1:0]     boot_prot;
   logic                           lock;
   logic [sps_pkg::N_SECT-1:0]     all_prot;
   logic [DW-1:0]                  dec_in;
   logic [7:0]                     reg_off;
   logic                           wr_ctrl;
   logic [7:0]                     main_status;
   logic [7:0]                     sec_status;
   logic [7:0]                     next_data_out;
   logic                           req_prot;
   logic                           req_alters;
   logic                           rc_cmd;
   logic                           rc_allowed;
   sps_rc_e                        rc_state;
   sps_rc_e                        next_rc_state;
   logic [CW-1:0]                  rc_cnt;
   logic [DW+sps_pkg::N_CNTL-1:0]  pld_in;
   logic [DW+sps_pkg::N_CNTL-1:0]  pld_prev;
   logic [3:0]                     stable_cnt;

   // Every processor pin passes two flip-flops before use; controls pass
   // inverted so the cleared synchroniser reads as idle strobes and no
   // false strobe edge follows reset
   sps_sync #(.W(SW)) u_sync (
      .sys_clk  (sys_clk),
      .rst_b    (rst_b),
      .pin_in   ({addr_pin, data_in_pin, ~cntl_pin}),
      .sync_out (sync_bus)
   );
   assign addr_s = sync_bus[SW-1 -: sps_pkg::ADDR_W];
   assign data_s = sync_bus[sps_pkg::N_CNTL +: 8];
   assign cntl_s = ~sync_bus[sps_pkg::N_CNTL-1:0];

   // Bit 0 is the write strobe, bit 1 the read strobe, both active low
   assign wr_end = cntl_s[0] && !wr_prev;
   assign rd_act = !cntl_s[1];

   // Page bits join the address in every select input; only the main sector terms compare them
   assign dec_in = {page_outputs, addr_s};  // [R16]

   // Sector selects: three product terms, the last two spare
   for (genvar i = 0; i < sps_pkg::N_MAIN; i++) begin : g_main
      sps_term_match #(
         .NT    (sps_pkg::N_PT),
         .MASK  ({sps_pkg::TERM_NONE, sps_pkg::TERM_NONE, sps_pkg::MAIN_MASK}),
         .VALUE ({sps_pkg::TERM_NONE, sps_pkg::TERM_NONE,
                  DW'(sps_pkg::MAIN_VAL + sps_pkg::MAIN_STEP * i)}),
         .EN    (3'b001)
      ) u_sel (.dec_in(dec_in), .hit(main_sector_selects[i]));  // [R19]
   end
   for (genvar i = 0; i < sps_pkg::N_BOOT; i++) begin : g_boot
      sps_term_match #(
         .NT    (sps_pkg::N_PT),
         .MASK  ({sps_pkg::TERM_NONE, sps_pkg::TERM_NONE, sps_pkg::BOOT_MASK}),
         .VALUE ({sps_pkg::TERM_NONE, sps_pkg::TERM_NONE,
                  DW'(sps_pkg::BOOT_VAL + sps_pkg::BOOT_STEP * i)}),
         .EN    (3'b001)
      ) u_sel (.dec_in(dec_in), .hit(boot_sector_selects[i]));  // [R19]
   end
   // External selects: a single product term each
   for (genvar i = 0; i < sps_pkg::N_ECS; i++) begin : g_ecs
      sps_term_match #(
         .NT    (1),
         .MASK  (sps_pkg::BLK_MASK),
         .VALUE (DW'(sps_pkg::ECS_VAL + sps_pkg::ECS_STEP * i)),
         .EN    (1'b1)
      ) u_sel (.dec_in(dec_in), .hit(external_selects[i]));  // [R22]
   end
   sps_term_match #(
      .NT (1), .MASK (sps_pkg::BLK_MASK), .VALUE (sps_pkg::CTRL_VAL), .EN (1'b1)
   ) u_ctrl (.dec_in(dec_in), .hit(ctrl_block_sel));  // [R20]
   sps_term_match #(
      .NT (1), .MASK (sps_pkg::BLK_MASK), .VALUE (sps_pkg::JTAG_VAL), .EN (1'b1)
   ) u_jtag (.dec_in(dec_in), .hit(jtag_sel));  // [R21]

   // Control block access; the low address byte is the offset
   assign reg_off     = addr_s[7:0];
   assign wr_ctrl     = wr_end && ctrl_block_sel;
   assign main_status = main_prot;  // [R5]
   assign sec_status  = {lock, 3'b000, boot_prot};  // [R6]
   assign next_data_out =
      (reg_off == sps_pkg::OFF_PAGE)      ? page_outputs :  // [R14]
      (reg_off == sps_pkg::OFF_MAIN_PROT) ? main_status :
      (reg_off == sps_pkg::OFF_SEC_PROT)  ? sec_status :
      (reg_off == sps_pkg::OFF_PMODE0)    ? pmode0 :
      (reg_off == sps_pkg::OFF_PMODE2)    ? pmode2 : sps_pkg::REG_NONE;
   // Drive only while the control block is read; flash reads are elsewhere
   assign data_oe = rd_act && ctrl_block_sel;

   // Strobe edge tracking and read data register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_prev  <= 1'b1;
         data_out <= sps_pkg::REG_NONE;
      end else begin
         wr_prev <= cntl_s[0];
         if (data_oe) begin
            data_out <= next_data_out;
         end
      end
   end

   // Writable registers latch on the trailing edge of the write strobe
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         page_outputs <= sps_pkg::PAGE_RST;  // [R15]
         pmode0       <= sps_pkg::PMODE0_RST;
         pmode2       <= sps_pkg::PMODE2_RST;
      end else if (wr_ctrl) begin
         if (reg_off == sps_pkg::OFF_PAGE) begin
            page_outputs <= data_s;  // [R14]
         end
         if (reg_off == sps_pkg::OFF_PMODE0) begin
            pmode0 <= data_s;
         end
         if (reg_off == sps_pkg::OFF_PMODE2) begin
            pmode2 <= data_s;
         end
      end
   end

   // Protection and lock change only from the programmer port; the
   // processor write path above has no route into them
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         main_prot <= sps_pkg::MAIN_PROT_RST;
         boot_prot <= sps_pkg::BOOT_PROT_RST;
         lock      <= 1'b0;
      end else if (prog_cmd.chip_erase) begin
         main_prot <= sps_pkg::MAIN_PROT_RST;  // [R8]
         boot_prot <= sps_pkg::BOOT_PROT_RST;
         lock      <= 1'b0;
      end else if (prog_cmd.wr && !lock) begin  // [R2] [R7]
         if (prog_cmd.sel == sps_pkg::SEL_LOCK) begin
            lock <= prog_cmd.val;
         end else if (prog_cmd.sel < 4'(sps_pkg::N_MAIN)) begin
            main_prot[prog_cmd.sel[2:0]] <= prog_cmd.val;  // [R1]
         end else if (prog_cmd.sel < 4'(sps_pkg::N_SECT)) begin
            boot_prot[prog_cmd.sel[1:0]] <= prog_cmd.val;  // [R1]
         end
      end
   end
   assign prog_access_ok = !lock;  // [R7]

   // Program and erase to a protected sector never reach the array;
   // a bulk erase is dropped if any sector in its array is protected
   assign all_prot   = {boot_prot, main_prot};
   assign req_alters = flash_req.op != sps_pkg::OP_VERIFY;
   assign req_prot   =
      (flash_req.sector >= 4'(sps_pkg::N_SECT)) ? 1'b1 :
      (flash_req.op != sps_pkg::OP_BULK_ERASE)   ? all_prot[flash_req.sector] :
      (flash_req.sector < 4'(sps_pkg::N_MAIN))   ? |main_prot : |boot_prot;
   // Verify always passes so the stored data is read back; the lock is
   // not in this path, so processor reads go on while locked [R9]
   assign array_req_valid = flash_req_valid && !(req_alters && req_prot);  // [R3] [R4]
   assign req_discarded   = flash_req_valid && req_alters && req_prot;  // [R3]
   assign array_req       = flash_req;

   // A reset command is one write of the reset code to any flash sector
   assign rc_cmd = wr_end && (|main_sector_selects || |boot_sector_selects) &&
                   data_s == sps_pkg::CMD_RESET;
   // Program and bulk erase cannot be interrupted; sector erase aborts
   assign rc_allowed = flash_state != sps_pkg::FL_PROGRAM &&
                       flash_state != sps_pkg::FL_BULK;  // [R12] [R13]
   assign reset_busy = rc_state == RC_BUSY;

   // Command state: idle until accepted, busy while the reset completes
   always_comb begin
      next_rc_state = rc_state;
      unique case (rc_state)
         RC_IDLE: begin
            if (rc_cmd && rc_allowed) begin
               next_rc_state = RC_BUSY;
            end
         end
         RC_BUSY: begin
            if (rc_cnt == RESET_LAST) begin
               next_rc_state = RC_IDLE;
            end
         end
         default: next_rc_state = RC_IDLE;
      endcase
   end

   // Reset pulse and completion count
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rc_state       <= RC_IDLE;
         rc_cnt         <= '0;
         flash_sm_reset <= 1'b0;
      end else begin
         rc_state       <= next_rc_state;
         flash_sm_reset <= rc_state == RC_IDLE && next_rc_state == RC_BUSY;  // [R10]
         rc_cnt         <= reset_busy ? rc_cnt + 1'b1 : '0;
      end
   end

   // Power mode bits block control signals from the logic arrays
   assign cntl_to_logic = cntl_s & ~pmode2[sps_pkg::N_CNTL-1:0];  // [R18]
   assign pld_in        = {cntl_to_logic, dec_in};

   // Standby once turbo is off and inputs held still long enough;
   // the counter saturates so long idle periods cost nothing more
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pld_prev   <= '0;
         stable_cnt <= '0;
      end else begin
         pld_prev <= pld_in;
         if (pld_in != pld_prev) begin
            stable_cnt <= '0;
         end else if (stable_cnt != STBY_LAST) begin
            stable_cnt <= stable_cnt + 1'b1;
         end
      end
   end
   assign pld_standby = !pmode0[sps_pkg::TURBO_BIT] && stable_cnt == STBY_LAST;  // [R17]

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence s_reset_taken;
      rc_cmd && rc_allowed && rc_state == RC_IDLE;
   endsequence
   sequence s_reset_runs;
      flash_sm_reset ##0 reset_busy [*8];
   endsequence

   a_page_write: assert property (  // [R14]
      wr_ctrl && reg_off == sps_pkg::OFF_PAGE |=> page_outputs == $past(data_s))
      else $error("page register missed a write");
   a_status_ro: assert property (  // [R2]
      wr_ctrl && !prog_cmd.wr && !prog_cmd.chip_erase |=> $stable(all_prot) && $stable(lock))
      else $error("processor write changed protection");
   a_prot_drop: assert property (  // [R3]
      flash_req_valid && req_alters && all_prot[flash_req.sector] &&
      flash_req.op != sps_pkg::OP_BULK_ERASE && flash_req.sector < 4'(sps_pkg::N_SECT)
      |-> !array_req_valid && req_discarded)
      else $error("protected sector request reached array");
   a_verify_pass: assert property (  // [R4]
      flash_req_valid && flash_req.op == sps_pkg::OP_VERIFY |-> array_req_valid)
      else $error("verify request was dropped");
   a_lock_refuse: assert property (  // [R7]
      lock && !prog_cmd.chip_erase |=> $stable(all_prot) && lock)
      else $error("locked device accepted programmer write");
   a_lock_clear: assert property (  // [R8]
      $fell(lock) |-> $past(prog_cmd.chip_erase))
      else $error("lock cleared without chip erase");
   a_reset_issue: assert property (  // [R10]
      s_reset_taken |=> s_reset_runs)
      else $error("accepted reset did not start");
   a_reset_ignore: assert property (  // [R12]
      rc_cmd && (flash_state == sps_pkg::FL_PROGRAM || flash_state == sps_pkg::FL_BULK)
      && rc_state == RC_IDLE |=> !flash_sm_reset && !reset_busy)
      else $error("reset accepted during program or bulk erase");
   a_erase_abort: assert property (  // [R13]
      rc_cmd && flash_state == sps_pkg::FL_SECTOR && rc_state == RC_IDLE |=> flash_sm_reset)
      else $error("reset did not abort sector erase");
   a_standby_wait: assert property (  // [R17]
      $rose(pld_standby) |-> $past(pld_in, 8) == pld_in && !pmode0[sps_pkg::TURBO_BIT])
      else $error("standby entered before inputs were stable");
   a_cntl_gate: assert property (  // [R18]
      (cntl_to_logic & pmode2[sps_pkg::N_CNTL-1:0]) == '0)
      else $error("blocked control signal reached logic");
endmodule

// ==== hw/sps_sync.sv ====
/*
 * Two-stage synchroniser for a vector of pin levels.
 * Assumes each bit is a level that settles between strobe edges.
 */
`timescale 1ns/10ps
module sps_sync #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rst_b,
   // Levels
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] stage1;

   // First stage read only by the second
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= pin_in;
         sync_out <= stage1;
      end
   end
endmodule

// ==== hw/sps_term_match.sv ====
/*
 * One decode select built as an OR of masked-compare product terms.
 * Assumes terms are fixed at elaboration; a disabled term never hits.
 */
`timescale 1ns/10ps
module sps_term_match #(
   parameter int                       NT    = 3,
   parameter logic [NT*sps_pkg::DEC_W-1:0] MASK  = '0,
   parameter logic [NT*sps_pkg::DEC_W-1:0] VALUE = '0,
   parameter logic [NT-1:0]            EN    = '0
) (
   // Decode inputs and select
   input  wire logic [sps_pkg::DEC_W-1:0] dec_in,
   output logic                           hit
);
   logic [NT-1:0] term_hit;

   // Each term compares only its masked bits
   for (genvar t = 0; t < NT; t++) begin : g_term
      assign term_hit[t] = EN[t] &&
         (((dec_in ^ VALUE[t*sps_pkg::DEC_W +: sps_pkg::DEC_W]) &
           MASK[t*sps_pkg::DEC_W +: sps_pkg::DEC_W]) == '0);
   end
   assign hit = |term_hit;
endmodule

// ==== tb/sps_dsp_model.sv ====
/* Processor bus master model driving the port pins of the block.
   Assumes a two-stage pin synchroniser, write strobe held 4 cycles, read 5. */
`timescale 1ns/10ps
module sps_dsp_model (
   // Clock and answer
   input  wire logic        sys_clk,
   input  wire logic [7:0]  data_out,
   input  wire logic        data_oe,
   // Pins driven
   output logic      [15:0] addr_pin,
   output logic      [7:0]  data_in_pin,
   output logic      [4:0]  cntl_pin
);
   // Idle strobes high from time zero
   initial begin
      addr_pin = 16'h0000;
      data_in_pin = 8'hFF;
      cntl_pin = 5'h03;
   end
   // Pass n edges, then the common drive delay
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // Hold an address until the synchroniser has settled
   task automatic at(input logic [15:0] a);
      tick(1);
      addr_pin = a;
      tick(3);
   endtask
   // Address and data outlast the edge detect of the strobe
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      tick(1);
      addr_pin = a;
      data_in_pin = d;
      cntl_pin[0] = 1'b0;
      tick(4);
      cntl_pin[0] = 1'b1;
      tick(5);
      data_in_pin = ~d;  // Released bus shows no stale byte
   endtask
   // Data taken at an edge while the block still drives it
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      tick(1);
      addr_pin = a;
      cntl_pin[1] = 1'b0;
      repeat (5) @(posedge sys_clk);
      d = (data_oe === 1'b1) ? data_out : 8'hXX;
      #1;
      cntl_pin[1] = 1'b1;
      tick(4);
   endtask
endmodule

// ==== tb/sps_protect_decode_test.sv ====
/* Self-checking bench for protection, page register and decode.
   Assumes the bus master model drives the pins; the rest comes from here. */
`timescale 1ns/10ps
module sps_protect_decode_test;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [15:0] addr_pin;
   logic [7:0] data_in_pin, data_out, page_outputs, rd_val;
   logic [4:0] cntl_pin, cntl_to_logic;
   logic [7:0] main_sector_selects;
   logic [3:0] boot_sector_selects;
   logic [2:0] external_selects;
   logic data_oe, prog_access_ok, flash_req_valid, array_req_valid, req_discarded;
   logic flash_sm_reset, reset_busy, ctrl_block_sel, jtag_sel, pld_standby;
   sps_pkg::sps_prog_cmd_s prog_cmd;
   sps_pkg::sps_flash_req_s flash_req, array_req;
   sps_pkg::sps_flash_e flash_state;
   int errors = 0, checks = 0, pulses = 0, p0;
   sps_protect_decode #(.RESET_CYC(20)) i_dut (.*);
   sps_dsp_model i_dsp (.*);
   always #4 sys_clk = ~sys_clk;
   // Count reset pulses of the flash command machine
   always @(posedge sys_clk) if (flash_sm_reset === 1'b1) pulses <= pulses + 1;
   task automatic give_verdict;
      if (errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
      i_dsp.rd(a, rd_val);
      chk("register read", e, rd_val);
   endtask
   // One-cycle request; the answer is combinational in that cycle
   task automatic freq(input sps_pkg::sps_op_e op, input logic [3:0] s, input logic fwd);
      @(posedge sys_clk);
      #1;
      flash_req_valid = 1'b1;
      flash_req = '{op, s};
      #1;
      chk("array_req_valid", fwd, array_req_valid);
      chk("req_discarded", !fwd, req_discarded);
      chk("array_req", {2'h0, op, s}, array_req);
      @(posedge sys_clk);
      #1;
      flash_req_valid = 1'b0;
   endtask
   task automatic prog(input logic [3:0] s, input logic v, input logic ce);
      @(posedge sys_clk);
      #1;
      prog_cmd = '{!ce, s, v, ce};
      @(posedge sys_clk);
      #1;
      prog_cmd = '0;
   endtask
   // Watchdog well beyond the expected run of about 430 cycles
   initial begin
      #100000;
      errors++;
      give_verdict;
   end
   initial begin
      flash_req_valid = 1'b0;
      flash_req = '0;
      flash_state = sps_pkg::FL_IDLE;
      prog_cmd = '0;
      repeat (10) @(posedge sys_clk);
      #1;
      rst_b = 1'b1;
      chk("page_outputs", 8'h00, page_outputs);
      rdchk(16'h30E0, 8'h00);
      rdchk(16'h3010, 8'h00);
      i_dsp.wr(16'h30E0, 8'hA5);
      chk("page_outputs", 8'hA5, page_outputs);
      rdchk(16'h30E0, 8'hA5);
      i_dsp.wr(16'h30C0, 8'hFF);
      rdchk(16'h30C0, 8'h00);
      // Page bits steer the main sector selects
      for (int i = 0; i < 8; i++) begin
         i_dsp.wr(16'h30E0, 8'(i));
         i_dsp.at(16'h8000);
         chk("main_sector_selects", 8'h01 << i, main_sector_selects);
      end
      for (int i = 0; i < 4; i++) begin
         i_dsp.at(16'h4000 + 16'(i << 12));
         chk("boot_sector_selects", 8'h01 << i, boot_sector_selects);
      end
      for (int i = 0; i < 3; i++) begin
         i_dsp.at(16'h2000 + 16'(i << 8));
         chk("external_selects", 8'h01 << i, external_selects);
      end
      i_dsp.at(16'h3000);
      chk("ctrl_block_sel", 8'h01, ctrl_block_sel);
      i_dsp.at(16'h3100);
      chk("jtag_sel", 8'h01, jtag_sel);
      // Protection set by the programmer, seen and obeyed
      prog(4'h2, 1'b1, 1'b0);
      prog(4'h9, 1'b1, 1'b0);
      rdchk(16'h30C0, 8'h04);
      rdchk(16'h30C2, 8'h02);
      freq(sps_pkg::OP_PROGRAM, 4'h2, 1'b0);
      freq(sps_pkg::OP_SECTOR_ERASE, 4'h9, 1'b0);
      freq(sps_pkg::OP_BULK_ERASE, 4'h0, 1'b0);
      freq(sps_pkg::OP_VERIFY, 4'h2, 1'b1);
      freq(sps_pkg::OP_PROGRAM, 4'h3, 1'b1);
      prog(4'hF, 1'b1, 1'b0);
      chk("prog_access_ok", 8'h00, prog_access_ok);
      rdchk(16'h30C2, 8'h82);
      prog(4'h2, 1'b0, 1'b0);
      rdchk(16'h30C0, 8'h04);
      freq(sps_pkg::OP_VERIFY, 4'h3, 1'b1);
      prog(4'h0, 1'b0, 1'b1);
      chk("prog_access_ok", 8'h01, prog_access_ok);
      rdchk(16'h30C2, 8'h00);
      // Reset command in every array state, after the status reads
      for (int k = 0; k < 4; k++) begin
         flash_state = sps_pkg::sps_flash_e'(k);
         p0 = pulses;
         i_dsp.wr(16'h8000, 8'hF0);
         chk("reset pulses", (k == 0 || k == 3), 8'(pulses - p0));
         repeat (40) if (reset_busy === 1'b1) @(posedge sys_clk);
         #1;
         chk("reset_busy", 8'h00, reset_busy);
      end
      // Mid-run reset clears the page register again
      rst_b = 1'b0;
      i_dsp.tick(2);
      rst_b = 1'b1;
      chk("page_outputs", 8'h00, page_outputs);
      // Standby with turbo off, then signal blocking
      i_dsp.wr(16'h30B0, 8'h00);
      i_dsp.tick(14);
      chk("pld_standby", 8'h01, pld_standby);
      // An input change restarts the nine-cycle stable count
      i_dsp.at(16'h3100);
      chk("pld_standby", 8'h00, pld_standby);
      i_dsp.tick(8);
      chk("pld_standby", 8'h00, pld_standby);
      i_dsp.tick(1);
      chk("pld_standby", 8'h01, pld_standby);
      i_dsp.wr(16'h30B0, 8'h08);
      chk("pld_standby", 8'h00, pld_standby);
      chk("cntl_to_logic", 8'h03, cntl_to_logic);
      i_dsp.wr(16'h30B4, 8'h1F);
      chk("cntl_to_logic", 8'h00, cntl_to_logic);
      give_verdict;
   end
endmodule
